// [hw/pscm_map.vh]
`ifndef PSCM_MAP_VH
`define PSCM_MAP_VH

// command codes, first byte on the link is the low byte
`define PSCM_CMD_GET_PID 32'h64697067
`define PSCM_CMD_SET_PID 32'h64697073
`define PSCM_CMD_SET_TRIG 32'h696E7373
`define PSCM_CMD_GET_TRIG 32'h696E7367
`define PSCM_CMD_SET_SOUT 32'h6F6E7373

// frame lengths in bytes, code and checksum included, the echo is the code alone
`define PSCM_LEN_PID 6'd48
`define PSCM_LEN_TRIG 6'd28
`define PSCM_LEN_ECHO 6'd4
// payload bytes between code and checksum
`define PSCM_PAY_PID 6'd42
`define PSCM_PAY_TRIG 6'd22
`define PSCM_PAY_SOUT 6'd10
// bytes of each payload kept in the settings memory, and where
`define PSCM_NST_PID 5'd6
`define PSCM_NST_TRIG 5'd14
`define PSCM_BASE_PID 5'd0
`define PSCM_BASE_TRIG 5'd6
`define PSCM_MEM_BYTES 20

// factory defaults: gains 0x0100/0x0010/0x0001, trigger settings zero
`define PSCM_MEM_DEFAULT 160'h0000000000000000000000000000000100100100

// flag bits of the trigger flag byte
`define PSCM_TF_ON 0
`define PSCM_TF_FALL 1
`define PSCM_TF_ABS 2

// value limits
`define PSCM_FRAC_MAX 16'sd255
`define PSCM_FRAC_MIN -16'sd255
`define PSCM_SPEED_MAX 32'd100000

// timing: dead time unit and clock period in ns
`define PSCM_DEAD_UNIT_NS 1000
`define PSCM_CLK_PERIOD_NS 5
`define PSCM_US_CYC (`PSCM_DEAD_UNIT_NS / `PSCM_CLK_PERIOD_NS)

// register byte offsets on the control bus
`define PSCM_REG_CTRL 8'h00
`define PSCM_REG_STATUS 8'h04
`define PSCM_REG_TRIGCNT 8'h08
`define PSCM_CTRL_RESET 32'h00000001
`define PSCM_RESP_OKAY 2'b00
`define PSCM_RESP_SLVERR 2'b10

`endif

// [hw/pscm_setmem.v]
`timescale 1ns/1ps
`include "pscm_map.vh"

module pscm_setmem (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire we_i,
  input wire [4:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [4:0] raddr_i,
  output reg [7:0] rdata_o,
  output wire [8*`PSCM_MEM_BYTES-1:0] all_o
);

  localparam [8*`PSCM_MEM_BYTES-1:0] DEFAULTS = `PSCM_MEM_DEFAULT;

  ////////////////////////////////////////////////////////////////////////
  // one byte cell each, reset loads the non-volatile defaults
  genvar i;
  generate
    for (i = 0; i < `PSCM_MEM_BYTES; i = i + 1) begin : g_cell
      reg [7:0] cell_q;
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cell_q <= DEFAULTS[i*8 +: 8];
        end else if (we_i && waddr_i == i) begin
          cell_q <= wdata_i;
        end
      end
      assign all_o[i*8 +: 8] = cell_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registered read port, out of range reads give zero
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (raddr_i < `PSCM_MEM_BYTES) begin
      rdata_o <= all_o[raddr_i*8 +: 8];
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// [hw/pscm_top.v]
// Summary of operation
// - code 64697067 reads gains, 48-byte answer
// - answer: three gains, 36 reserved, checksum
// - read answer uses gains held in memory
// - accepted gain write stored, 4-byte echo
// - code 64697073 writes gains, 48-byte request
// - defaults in non-volatile memory before writes
// - code 696E7373 writes trigger, 28 bytes, echo
// - trigger input acts only when flag 0x01
// - flag 0x02 selects falling edge, else rising
// - flag 0x04 absolute move, else relative
// - dead time in microseconds after pulse
// - target steps plus fraction clamped to 255
// - move speed unsigned, limited to 100000
// - speed fraction applied for stepper only
// - code 696E7367 returns 28-byte trigger settings
// - code 6F6E7373 decoded distinctly from others
// - output sync write 16 bytes, 4-byte echo
`timescale 1ns/1ps
`include "pscm_map.vh"

module pscm_top (
  input wire ref_clk_i,
  input wire resetn_i,
  // command byte stream
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  output wire rx_ready_o,
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  input wire tx_ready_i,
  // motion side
  input wire trig_in_i,
  input wire stepper_mode_i,
  output reg trig_pulse_o,
  output reg trig_in_absolute_move_o,
  output reg [31:0] trig_position_o,
  output reg [15:0] target_microstep_fraction_o,
  output reg [31:0] trig_speed_o,
  output reg [7:0] speed_microstep_fraction_o,
  output wire [15:0] voltage_prop_gain_o,
  output wire [15:0] voltage_integral_gain_o,
  output wire [15:0] voltage_deriv_gain_o,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [2:0] S_CODE = 3'd0;
  localparam [2:0] S_PAY = 3'd1;
  localparam [2:0] S_CRC = 3'd2;
  localparam [2:0] S_COMMIT = 3'd3;
  localparam [2:0] S_LOAD = 3'd4;
  localparam [2:0] S_PREP = 3'd5;
  localparam [2:0] S_SEND = 3'd6;
  localparam integer US_CYC_W = `PSCM_US_CYC;
  localparam [7:0] US_CYC = US_CYC_W[7:0];

  reg [2:0] st_q;
  reg [5:0] cnt_q;
  reg [31:0] code_q;
  reg [15:0] sum_q;
  reg [7:0] crc_lo_q;
  reg [5:0] plen_q;
  reg [5:0] tlen_q;
  reg [4:0] nst_q;
  reg [4:0] base_q;
  reg [111:0] stage_q;
  reg [15:0] crc_err_q;
  reg [31:0] ctrl_q;
  wire [159:0] mem_all;
  wire [7:0] mem_rdata;
  wire [31:0] code_new = {rx_data_i, code_q[31:8]};
  wire rx_fire = rx_valid_i & rx_ready_o;
  wire [5:0] pidx = cnt_q - 6'd4;

  ////////////////////////////////////////////////////////////////////////
  // settings memory and its views
  pscm_setmem u_mem (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .we_i(st_q == S_COMMIT && cnt_q[4:0] < nst_q),
    .waddr_i(base_q + cnt_q[4:0]),
    .wdata_i(stage_q[cnt_q[3:0]*8 +: 8]),
    .raddr_i(base_q + pidx[4:0]),
    .rdata_o(mem_rdata),
    .all_o(mem_all)
  );

  // gains straight from storage, reset loads defaults
  assign voltage_prop_gain_o = mem_all[15:0];
  assign voltage_integral_gain_o = mem_all[31:16];
  assign voltage_deriv_gain_o = mem_all[47:32];

  wire [7:0] t_flags = mem_all[55:48];
  wire [15:0] t_dead = mem_all[71:56];
  wire [31:0] t_pos = mem_all[103:72];
  wire signed [15:0] t_frac = mem_all[119:104];
  wire [31:0] t_speed = mem_all[151:120];
  wire [7:0] t_sfrac = mem_all[159:152];

  // receive only in input states and while software enables frames
  assign rx_ready_o = ctrl_q[0] && (st_q == S_CODE || st_q == S_PAY ||
                      st_q == S_CRC);

  ////////////////////////////////////////////////////////////////////////
  // frame interpreter
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= S_CODE;
      cnt_q <= 6'd0;
      code_q <= 32'h00000000;
      sum_q <= 16'h0000;
      crc_lo_q <= 8'h00;
      plen_q <= 6'd0;
      tlen_q <= 6'd0;
      nst_q <= 5'd0;
      base_q <= 5'd0;
      stage_q <= 112'h0;
      crc_err_q <= 16'h0000;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      case (st_q)
        S_CODE: begin
          if (rx_fire) begin
            code_q <= code_new;
            cnt_q <= cnt_q + 6'd1;
            sum_q <= 16'h0000;
            if (cnt_q == 6'd3) begin
              cnt_q <= 6'd0;
              case (code_new)
                `PSCM_CMD_GET_PID: begin
                  tlen_q <= `PSCM_LEN_PID;
                  nst_q <= `PSCM_NST_PID;
                  base_q <= `PSCM_BASE_PID;
                  st_q <= S_LOAD;
                end
                `PSCM_CMD_GET_TRIG: begin
                  tlen_q <= `PSCM_LEN_TRIG;
                  nst_q <= `PSCM_NST_TRIG;
                  base_q <= `PSCM_BASE_TRIG;
                  st_q <= S_LOAD;
                end
                `PSCM_CMD_SET_PID: begin
                  plen_q <= `PSCM_PAY_PID;
                  nst_q <= `PSCM_NST_PID;
                  base_q <= `PSCM_BASE_PID;
                  st_q <= S_PAY;
                end
                `PSCM_CMD_SET_TRIG: begin
                  plen_q <= `PSCM_PAY_TRIG;
                  nst_q <= `PSCM_NST_TRIG;
                  base_q <= `PSCM_BASE_TRIG;
                  st_q <= S_PAY;
                end
                `PSCM_CMD_SET_SOUT: begin
                  plen_q <= `PSCM_PAY_SOUT;
                  nst_q <= 5'd0;
                  base_q <= 5'd0;
                  st_q <= S_PAY;
                end
                default: begin
                  st_q <= S_CODE; // unknown code dropped
                end
              endcase
            end
          end
        end
        S_PAY: begin
          if (rx_fire) begin
            sum_q <= sum_q + {8'h00, rx_data_i};
            // full count compared, byte 32 on must not alias byte 0
            if (cnt_q < {1'b0, nst_q}) begin
              stage_q[cnt_q[3:0]*8 +: 8] <= rx_data_i;
            end
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == plen_q - 6'd1) begin
              cnt_q <= 6'd0;
              st_q <= S_CRC;
            end
          end
        end
        S_CRC: begin
          if (rx_fire) begin
            crc_lo_q <= rx_data_i;
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == 6'd1) begin
              cnt_q <= 6'd0;
              tlen_q <= `PSCM_LEN_ECHO;
              // mismatch leaves storage untouched
              if ({rx_data_i, crc_lo_q} == sum_q) begin
                st_q <= S_COMMIT;
              end else begin
                crc_err_q <= crc_err_q + 16'h0001;
                st_q <= S_CODE;
              end
            end
          end
        end
        S_COMMIT: begin
          // staged bytes written one per cycle, then echo
          if (cnt_q[4:0] == nst_q) begin
            cnt_q <= 6'd0;
            sum_q <= 16'h0000;
            st_q <= S_LOAD;
          end else begin
            cnt_q <= cnt_q + 6'd1;
          end
        end
        S_LOAD: begin
          st_q <= S_PREP; // memory read address settles here
        end
        S_PREP: begin
          tx_valid_o <= 1'b1;
          st_q <= S_SEND;
          if (cnt_q < 6'd4) begin
            tx_data_o <= code_q[cnt_q[1:0]*8 +: 8];
          end else if (cnt_q == tlen_q - 6'd2) begin
            tx_data_o <= sum_q[7:0];
          end else if (cnt_q == tlen_q - 6'd1) begin
            tx_data_o <= sum_q[15:8];
          end else if (pidx < {1'b0, nst_q}) begin
            tx_data_o <= mem_rdata; // live stored values
            sum_q <= sum_q + {8'h00, mem_rdata};
          end else begin
            tx_data_o <= 8'h00; // reserved bytes
          end
        end
        S_SEND: begin
          if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            if (cnt_q == tlen_q - 6'd1) begin
              cnt_q <= 6'd0;
              st_q <= S_CODE;
            end else begin
              cnt_q <= cnt_q + 6'd1;
              st_q <= S_LOAD;
            end
          end
        end
        default: begin
          st_q <= S_CODE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger input: synchroniser, edge select, dead time
  reg sin_meta_q;
  reg sin_sync_q;
  reg sin_prev_q;
  reg [7:0] us_cnt_q;
  reg [15:0] dead_q;
  reg [15:0] trig_cnt_q;
  wire us_tick = (us_cnt_q == US_CYC - 8'd1);
  wire edge_rise = sin_sync_q & ~sin_prev_q;
  wire edge_fall = ~sin_sync_q & sin_prev_q;
  wire edge_sel = t_flags[`PSCM_TF_FALL] ? edge_fall : edge_rise;
  wire trig_fire = t_flags[`PSCM_TF_ON] && edge_sel &&
                   dead_q == 16'h0000;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sin_meta_q <= 1'b0;
      sin_sync_q <= 1'b0;
      sin_prev_q <= 1'b0;
    end else begin
      sin_meta_q <= trig_in_i;
      sin_sync_q <= sin_meta_q;
      sin_prev_q <= sin_sync_q;
    end
  end

  // divider restarts on a pulse so the dead time is never short
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      us_cnt_q <= 8'h00;
      dead_q <= 16'h0000;
    end else if (trig_fire) begin
      us_cnt_q <= 8'h00;
      dead_q <= t_dead;
    end else begin
      us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
      if (us_tick && dead_q != 16'h0000) begin
        dead_q <= dead_q - 16'h0001;
      end
    end
  end

  // move request sampled at the pulse, limits applied here
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_pulse_o <= 1'b0;
      trig_in_absolute_move_o <= 1'b0;
      trig_position_o <= 32'h00000000;
      target_microstep_fraction_o <= 16'h0000;
      trig_speed_o <= 32'h00000000;
      speed_microstep_fraction_o <= 8'h00;
      trig_cnt_q <= 16'h0000;
    end else begin
      trig_pulse_o <= trig_fire;
      if (trig_fire) begin
        trig_cnt_q <= trig_cnt_q + 16'h0001;
        trig_in_absolute_move_o <= t_flags[`PSCM_TF_ABS];
        trig_position_o <= t_pos;
        if (!stepper_mode_i) begin
          target_microstep_fraction_o <= 16'h0000;
        end else if (t_frac > `PSCM_FRAC_MAX) begin
          target_microstep_fraction_o <= `PSCM_FRAC_MAX;
        end else if (t_frac < `PSCM_FRAC_MIN) begin
          target_microstep_fraction_o <= `PSCM_FRAC_MIN;
        end else begin
          target_microstep_fraction_o <= t_frac;
        end
        trig_speed_o <= (t_speed > `PSCM_SPEED_MAX) ?
                        `PSCM_SPEED_MAX : t_speed;
        speed_microstep_fraction_o <= stepper_mode_i ?
                                      t_sfrac : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSCM_RESP_OKAY;
      ctrl_q <= `PSCM_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PSCM_RESP_OKAY;
        if (aw_addr_q == `PSCM_REG_CTRL) begin
          if (w_strb_q[0]) begin
            ctrl_q[0] <= w_data_q[0]; // only bit 0 is stored
          end
        end else if (aw_addr_q != `PSCM_REG_STATUS &&
                     aw_addr_q != `PSCM_REG_TRIGCNT) begin
          s_axi_bresp <= `PSCM_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side, one cycle after address accept
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PSCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PSCM_RESP_OKAY;
      case (s_axi_araddr)
        `PSCM_REG_CTRL: s_axi_rdata <= {31'h0, ctrl_q[0]};
        `PSCM_REG_STATUS: begin
          s_axi_rdata <= {crc_err_q, 11'h000, dead_q != 16'h0000,
                          ctrl_q[0], st_q};
        end
        `PSCM_REG_TRIGCNT: s_axi_rdata <= {16'h0000, trig_cnt_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PSCM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [verif/pscm_assertions.sv]
`timescale 1ns/1ps
module pscm_assertions (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire tx_ready_i,
  input wire rx_ready_o,
  input wire stepper_mode_i,
  input wire trig_pulse_o,
  input wire [15:0] target_microstep_fraction_o,
  input wire [31:0] trig_speed_o,
  input wire [7:0] speed_microstep_fraction_o,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // answer byte must not move before the host takes it
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("answer byte changed while stalled");
  property p_rx_shut;
    tx_valid_o |-> !rx_ready_o;
  endproperty
  a_rx_shut: assert property (p_rx_shut)
    else $error("request taken while answering");
  // one pulse per accepted edge
  property p_pulse_one;
    trig_pulse_o |=> !trig_pulse_o;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("trigger pulse longer than one cycle");
  property p_frac_lim;
    trig_pulse_o |-> $signed(target_microstep_fraction_o) <= 255 &&
      $signed(target_microstep_fraction_o) >= -255;
  endproperty
  a_frac_lim: assert property (p_frac_lim)
    else $error("target fraction out of range");
  property p_speed_lim;
    trig_pulse_o |-> trig_speed_o <= 32'd100000;
  endproperty
  a_speed_lim: assert property (p_speed_lim)
    else $error("move speed out of range");
  // dc motors get no fractions
  property p_dc_zero;
    trig_pulse_o && !stepper_mode_i |->
      target_microstep_fraction_o == 16'h0 &&
      speed_microstep_fraction_o == 8'h0;
  endproperty
  a_dc_zero: assert property (p_dc_zero)
    else $error("fraction passed in dc mode");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read answered twice");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write answered twice");
endmodule

// [verif/pscm_host.sv]
`timescale 1ns/1ps
module pscm_host (
  input wire ref_clk_i,
  input wire rx_ready_i,
  output reg rx_valid_o,
  output reg [7:0] rx_data_o,
  output reg tx_ready_o
);
  reg slow_q;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    tx_ready_o = 1'b0;
    slow_q = 1'b0;
  end
  // answer sink, stalls often when slow
  always @(posedge ref_clk_i) begin
    tx_ready_o <= !slow_q || ($urandom % 3 == 0);
  end
  // one frame byte, valid held across the frame
  task put(input [7:0] b, input bit last);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(negedge ref_clk_i);
    while (!rx_ready_i) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    if (last) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= ~b; // released line must not look valid
    end
  endtask
endmodule

// [verif/pscm_top_bench.sv]
`timescale 1ns/1ps
`include "pscm_map.vh"
module pscm_top_bench;
  logic clk, rstn, rxv, rxr, txv, txr, trg, stp, pls, ab;
  logic [7:0] rxd, txd, sfr, awa, ara;
  logic [15:0] fr, kp, ki, kd;
  logic [31:0] ps, sp, wd, rd, rp;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0] bres, rres;
  logic [7:0] pay [0:41];
  logic [7:0] tq[$];
  logic [33:0] aq[$];
  logic [88:0] pq[$];
  int bad_count, checks;

  pscm_top DUT (.ref_clk_i(clk), .resetn_i(rstn), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_ready_i(txr), .trig_in_i(trg), .stepper_mode_i(stp),
    .trig_pulse_o(pls), .trig_in_absolute_move_o(ab), .trig_position_o(ps),
    .target_microstep_fraction_o(fr), .trig_speed_o(sp),
    .speed_microstep_fraction_o(sfr), .voltage_prop_gain_o(kp),
    .voltage_integral_gain_o(ki), .voltage_deriv_gain_o(kd),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rres),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  pscm_host host (.ref_clk_i(clk), .rx_ready_i(rxr), .rx_valid_o(rxv),
    .rx_data_o(rxd), .tx_ready_o(txr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input string n, input [88:0] e, input [88:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // results are matched to the oldest note
  always @(posedge clk) begin
    if (txv && txr) chk("tx", tq.size() ? tq.pop_front() : 'x, txd);
    if (pls) chk("pulse", pq.size() ? pq.pop_front() : 'x,
      {ab, ps, fr, sp, sfr});
    if (bv && br) chk("bresp", aq.pop_front(), {bres, 32'h0});
    if (rv && rr) chk("read", aq.pop_front(), {rres, rd});
  end
  function automatic [15:0] csum(input int n);
    csum = 16'h0;
    for (int i = 0; i < n; i++) csum += pay[i];
  endfunction
  task le(input int o, input [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) pay[o + i] = v[8*i +: 8];
  endtask
  task clr;
    for (int i = 0; i < 42; i++) pay[i] = 8'h00;
  endtask
  // note an answer: code, payload, then its sum low byte first
  task expect_ans(input [31:0] c, input int n);
    logic [15:0] s;
    s = csum(n);
    for (int i = 0; i < 4; i++) tq.push_back(c[8*i +: 8]);
    for (int i = 0; i < n; i++) tq.push_back(pay[i]);
    if (n > 0) begin
      tq.push_back(s[7:0]);
      tq.push_back(s[15:8]);
    end
  endtask
  // send a request, err spoils its sum, then drain the answer
  task send(input [31:0] c, input int n, input bit err);
    logic [15:0] s;
    s = csum(n) + {15'h0, err};
    for (int i = 0; i < 4; i++) host.put(c[8*i +: 8], n == 0 && i == 3);
    for (int i = 0; i < n; i++) host.put(pay[i], 1'b0);
    if (n > 0) begin
      host.put(s[7:0], 1'b0);
      host.put(s[15:8], 1'b1);
    end
    repeat (3000) if (tq.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task axw(input [7:0] a, input [31:0] d, input [1:0] r);
    bit da, dw, ta, tw;
    aq.push_back({r, 32'h0});
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    da = 0;
    dw = 0;
    // each channel released at its own handshake
    while (!(da && dw)) begin
      @(negedge clk);
      ta = !da && awr;
      tw = !dw && wr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    @(negedge clk);
    while (!bv) @(negedge clk);
    @(posedge clk);
    br <= 1'b0;
    @(posedge clk);
  endtask
  task axr(input [7:0] a, input [31:0] d, input [1:0] r);
    aq.push_back({r, d});
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(negedge clk);
    while (!arr) @(negedge clk);
    @(posedge clk);
    arv <= 1'b0;
    @(negedge clk);
    while (!rv) @(negedge clk);
    @(posedge clk);
    rr <= 1'b0;
    @(posedge clk);
  endtask
  task pin(input bit v, input int gap);
    trg <= v;
    repeat (gap) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rstn = 0; trg = 0; stp = 1; awv = 0; wv = 0; br = 0; arv = 0;
    rr = 0; awa = 0; ara = 0; wd = 0; bad_count = 0; checks = 0;
    rp = $urandom(46324);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    clr;
    le(0, 32'h00100100, 4);
    le(4, 32'h1, 2);
    expect_ans(`PSCM_CMD_GET_PID, 42);
    send(`PSCM_CMD_GET_PID, 0, 0);
    $display("test default gains done");
    host.slow_q = 1'b1;
    for (int i = 0; i < 42; i++) pay[i] = 8'($urandom);
    expect_ans(`PSCM_CMD_SET_PID, 0);
    send(`PSCM_CMD_SET_PID, 42, 0);
    chk("gains", {pay[5], pay[4], pay[3], pay[2], pay[1], pay[0]},
      {kd, ki, kp});
    pay[0] = ~pay[0];
    send(`PSCM_CMD_SET_PID, 42, 1);
    pay[0] = ~pay[0];
    for (int i = 6; i < 42; i++) pay[i] = 8'h00;
    expect_ans(`PSCM_CMD_GET_PID, 42);
    send(`PSCM_CMD_GET_PID, 0, 0);
    $display("test gain write done");
    // rising edge, 2 us dead time, raw values read back
    rp = $urandom;
    clr;
    pay[0] = 8'h01;
    le(1, 2, 2);
    le(3, rp, 4);
    le(7, 300, 2);
    le(9, 200000, 4);
    pay[13] = 8'h07;
    expect_ans(`PSCM_CMD_SET_TRIG, 0);
    send(`PSCM_CMD_SET_TRIG, 22, 0);
    expect_ans(`PSCM_CMD_GET_TRIG, 22);
    send(`PSCM_CMD_GET_TRIG, 0, 0);
    pq.push_back({1'b0, rp, 16'h00FF, 32'd100000, 8'h07});
    pin(1, 20);
    pin(0, 20);
    pin(1, 20); // inside the dead time
    pin(0, 400);
    pq.push_back({1'b0, rp, 16'h00FF, 32'd100000, 8'h07});
    pin(1, 400); // let the dead time run out
    // falling edge, absolute, dc motor
    pay[0] = 8'h07;
    le(1, 0, 2);
    le(7, 16'hFED4, 2);
    expect_ans(`PSCM_CMD_SET_TRIG, 0);
    send(`PSCM_CMD_SET_TRIG, 22, 0);
    stp <= 1'b0;
    pq.push_back({1'b1, rp, 16'h0000, 32'd100000, 8'h00});
    pin(0, 20);
    pin(1, 20);
    pay[0] = 8'h06;
    expect_ans(`PSCM_CMD_SET_TRIG, 0);
    send(`PSCM_CMD_SET_TRIG, 22, 0);
    pin(0, 20);
    pin(1, 20);
    $display("test trigger done");
    for (int i = 0; i < 10; i++) pay[i] = 8'($urandom);
    expect_ans(`PSCM_CMD_SET_SOUT, 0);
    send(`PSCM_CMD_SET_SOUT, 10, 0);
    $display("test output sync done");
    axr(`PSCM_REG_CTRL, 32'h1, `PSCM_RESP_OKAY);
    axr(`PSCM_REG_STATUS, 32'h00010008, `PSCM_RESP_OKAY);
    axr(8'h0C, 32'h0, `PSCM_RESP_SLVERR);
    axr(`PSCM_REG_TRIGCNT, 32'd3, `PSCM_RESP_OKAY);
    axw(`PSCM_REG_CTRL, 32'h0, `PSCM_RESP_OKAY);
    @(negedge clk);
    chk("rx ready", 1'b0, rxr);
    @(posedge clk);
    axw(`PSCM_REG_CTRL, 32'h1, `PSCM_RESP_OKAY);
    axw(8'h0C, 32'h5, `PSCM_RESP_SLVERR);
    $display("test register bus done");
    chk("pending", 0, tq.size() + pq.size());
    test_done;
  end
  // watchdog, far beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done;
  end
  task test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
endmodule

bind pscm_top pscm_assertions u_chk (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_ready_i(tx_ready_i), .rx_ready_o(rx_ready_o),
  .stepper_mode_i(stepper_mode_i), .trig_pulse_o(trig_pulse_o),
  .target_microstep_fraction_o(target_microstep_fraction_o),
  .trig_speed_o(trig_speed_o),
  .speed_microstep_fraction_o(speed_microstep_fraction_o),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
